/* src/ohf_sequencer.sv */
// Purpose: overcurrent hiccup fault sequencer of a synchronous buck controller
// Assumes: analog comparators deliver flags; a switching period is PERIOD_CYC clocks
// Notes: gate outputs are registered; soft-start discharge is a registered output
// Notes: shutdown cannot cut a fault timeout short, so every restart after a fault is a full soft-start
`timescale 1ns/100ps
`include "ohf_defs.svh"
module ohf_sequencer #(
	parameter int PERIOD_CYC = `OHF_PERIOD_CYC,
	parameter int DUTY_PCT = `OHF_DUTY_MAX_PCT
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire ohf_pkg::ohf_flags_t i_flags,
	output logic o_high_side_gate_drive,
	output logic o_low_side_gate_drive,
	output logic o_softstart_discharge,
	output logic o_fault,
	output logic [2:0] o_oc_count
);
	import ohf_pkg::*;

	localparam int CW = $clog2(PERIOD_CYC + 1);
	localparam int BW = $clog2(`OHF_BLANK_CYC + 2);
	localparam logic [CW-1:0] PER_LAST = CW'(PERIOD_CYC - 1);
	localparam logic [CW-1:0] HI_MAX = CW'((PERIOD_CYC * DUTY_PCT) / 100);
	localparam logic [BW-1:0] BLANK = BW'(`OHF_BLANK_CYC);

	// Saturating step shared by all counter updates but the shutdown reset
	function automatic logic [2:0] sat_step(input logic [2:0] v, input logic up);
		if (up)
			sat_step = (v == `OHF_OC_FULL) ? v : v + 3'h1;
		else
			sat_step = (v == `OHF_OC_ZERO) ? v : v - 3'h1;
	endfunction

	// Last clock of a switching period; counting and pulse end hang off it
	function automatic logic period_end(input logic [CW-1:0] p);
		period_end = (p == PER_LAST);
	endfunction

	ohf_flags_t f;
	ohf_state_t st_r, st_nxt;
	logic [CW-1:0] ph_r, ph_nxt;
	logic [BW-1:0] bl_r, bl_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic hi_r, hi_nxt;
	logic lo_r, lo_nxt;
	logic dis_r, dis_nxt;
	logic flt_r, flt_nxt;
	logic trip_r, trip_nxt;
	logic tripped_now;
	logic oc_seen;
	logic [2:0] oc_next;

	// Flags cross in from the analog side
	ohf_sync #(.W($bits(ohf_flags_t))) u_sync (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_async(i_flags),
		.o_sync(f)
	);

	// Overcurrent only valid once phase is high and blanking is over
	assign tripped_now = hi_r && f.phase_high && (bl_r == BLANK) && f.oc_trip;

	// Blanking timer restarts each pulse and waits for the phase node to rise
	always_comb begin
		bl_nxt = bl_r;
		if (!hi_r || !f.phase_high)
			bl_nxt = '0;
		else if (bl_r != BLANK)
			bl_nxt = bl_r + BW'(1);
	end

	// Blanking register
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			bl_r <= '0;
		else
			bl_r <= bl_nxt;
	end

	// Trip latch, cleared at period start; a trip in the same clock wins
	always_comb begin
		trip_nxt = trip_r;
		if (ph_r == '0)
			trip_nxt = 1'b0;
		if (tripped_now)
			trip_nxt = 1'b1;
	end

	// Trip latch register
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			trip_r <= 1'b0;
		else
			trip_r <= trip_nxt;
	end

	// Counter step worked out once, used for update and fault decision
	assign oc_seen = trip_r || tripped_now;
	assign oc_next = sat_step(cnt_r, oc_seen);

	// Next-state logic for sequencer, period timer and drives
	always_comb begin
		st_nxt = st_r;
		ph_nxt = period_end(ph_r) ? '0 : ph_r + CW'(1);
		cnt_nxt = cnt_r;
		hi_nxt = 1'b0;
		lo_nxt = 1'b0;
		dis_nxt = 1'b0;
		flt_nxt = flt_r;
		case (st_r)
			OHF_SHUT: begin
				// Counter starts fresh after every shutdown
				ph_nxt = '0;
				cnt_nxt = `OHF_OC_RST;
				if (f.ss_above_on)
					st_nxt = OHF_PREBIAS;
			end
			OHF_PREBIAS: begin
				// No pulses until the reference passes a pre-biased output
				ph_nxt = '0;
				if (f.ss_above_fb)
					st_nxt = OHF_SOFT;
			end
			OHF_SOFT, OHF_RUN: begin
				// Pulse ends on trip, demand drop or the duty cap
				hi_nxt = f.pwm_demand && (ph_nxt < HI_MAX) && !trip_nxt
					&& !period_end(ph_r);
				// One idle clock after high-side turn-off and at period start stands in for dead time
				lo_nxt = !hi_nxt && !period_end(ph_r) && !hi_r;
				// Soft-start finished once reference has passed the 1.3 V level
				if (st_r == OHF_SOFT && f.ss_at_1v3)
					st_nxt = OHF_RUN;
				// One overcurrent sample per switching cycle, counted only in run
				if (st_r == OHF_RUN && period_end(ph_r)) begin
					cnt_nxt = oc_next;
					if (oc_next == `OHF_OC_FULL) begin
						st_nxt = OHF_FDIS;
						flt_nxt = 1'b1;
						cnt_nxt = sat_step(`OHF_OC_FULL, 1'b0);
						hi_nxt = 1'b0;
						lo_nxt = 1'b0;
						dis_nxt = 1'b1;
					end
				end
			end
			OHF_FDIS: begin
				// Both drives stay low for the whole timeout, shutdown or not
				ph_nxt = '0;
				dis_nxt = 1'b1;
				if (f.ss_empty) begin
					dis_nxt = 1'b0;
					st_nxt = OHF_FCHG;
				end
			end
			OHF_FCHG: begin
				// Cap charges at its normal rate; restart only once the count is spent
				ph_nxt = '0;
				if (cnt_r == `OHF_OC_ZERO) begin
					flt_nxt = 1'b0;
					st_nxt = OHF_SOFT;
				end else if (f.ss_at_1v3) begin
					cnt_nxt = sat_step(cnt_r, 1'b0);
					dis_nxt = 1'b1;
					st_nxt = OHF_FDIS;
				end
			end
			default: begin
				st_nxt = OHF_SHUT;
			end
		endcase
		// Shutdown overrides all states but the fault timeout ones (FDIS, FCHG), drives low
		if (f.ss_below_off && st_r != OHF_FDIS && st_r != OHF_FCHG) begin
			st_nxt = OHF_SHUT;
			dis_nxt = 1'b0;
			hi_nxt = 1'b0;
			lo_nxt = 1'b0;
			flt_nxt = 1'b0;
		end
	end

	// State registers only
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r <= OHF_SHUT;
			ph_r <= '0;
			cnt_r <= `OHF_OC_RST;
			hi_r <= 1'b0;
			lo_r <= 1'b0;
			dis_r <= 1'b0;
			flt_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			cnt_r <= cnt_nxt;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			dis_r <= dis_nxt;
			flt_r <= flt_nxt;
		end
	end

	// Outputs straight from flops
	assign o_high_side_gate_drive = hi_r;
	assign o_low_side_gate_drive = lo_r;
	assign o_softstart_discharge = dis_r;
	assign o_fault = flt_r;
	assign o_oc_count = cnt_r;
endmodule

/* src/ohf_defs.svh */
// Purpose: timing counts and reset values for the hiccup fault sequencer
// Assumes: 200 MHz core clock, 5 ns period
// Notes: definitions only
`ifndef OHF_DEFS_SVH
`define OHF_DEFS_SVH
`define OHF_CLK_PERIOD_NS 5
`define OHF_BLANK_NS 100
`define OHF_BLANK_CYC ((`OHF_BLANK_NS + `OHF_CLK_PERIOD_NS - 1) / `OHF_CLK_PERIOD_NS)
`define OHF_PERIOD_CYC 667
`define OHF_DUTY_MAX_PCT 94
`define OHF_OC_FULL 3'h7
`define OHF_OC_ZERO 3'h0
`define OHF_OC_RST 3'h0
`endif

/* src/ohf_pkg.sv */
// Purpose: types shared by the hiccup fault sequencer
// Assumes: nothing
// Notes: comparator flags travel in one packed struct
package ohf_pkg;
	typedef struct packed {
		logic oc_trip;
		logic phase_high;
		logic ss_empty;
		logic ss_at_1v3;
		logic ss_below_off;
		logic ss_above_on;
		logic ss_above_fb;
		logic pwm_demand;
	} ohf_flags_t;
	typedef enum logic [2:0] {
		OHF_SHUT, OHF_PREBIAS, OHF_SOFT, OHF_RUN, OHF_FDIS, OHF_FCHG
	} ohf_state_t;
endpackage

/* src/ohf_sync.sv */
// Purpose: two-flop synchroniser for a bundle of comparator flags
// Assumes: flags are asynchronous to i_clock
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module ohf_sync #(
	parameter int W = 8
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	// Plain double flop
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
		end
	end
	assign o_sync = s2_r;
endmodule

/* sim/ohf_seq_sva.sv */
// Purpose: port checker for the hiccup fault sequencer
// Assumes: bench holds flags steady for several cycles
// Notes: bound to every sequencer instance
`timescale 1ns/100ps
module ohf_seq_sva #(
	parameter int PERIOD_CYC = 667,
	parameter int DUTY_PCT = 94
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire ohf_pkg::ohf_flags_t i_flags,
	input wire logic o_high_side_gate_drive,
	input wire logic o_low_side_gate_drive,
	input wire logic o_softstart_discharge,
	input wire logic o_fault,
	input wire logic [2:0] o_oc_count
);
	logic [15:0] hs_len_r, hs_len_nxt;
	wire logic hs = o_high_side_gate_drive;
	wire logic ls = o_low_side_gate_drive;
	wire logic dis = o_softstart_discharge;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// Length of the current high-side pulse
	always_comb hs_len_nxt = hs ? hs_len_r + 16'h0001 : 16'h0000;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) hs_len_r <= 16'h0000;
		else hs_len_r <= hs_len_nxt;
	end
	sequence s_entry;
		o_oc_count == 3'h6 ##0 dis;
	endsequence
	AST_FAULT_OFF: assert property (o_fault |-> !hs && !ls)
		else $error("drive on in fault");
	AST_ENTRY: assert property ($rose(o_fault) |-> s_entry)
		else $error("bad fault entry");
	AST_STEP: assert property ($changed(o_oc_count) |->
		(int'(o_oc_count) - int'($past(o_oc_count)) inside {1, -1})
		|| (o_oc_count == 3'h0 && $past(!hs && !ls && !o_fault)))
		else $error("count jumped");
	AST_END: assert property ($fell(o_fault) |-> o_oc_count == 3'h0)
		else $error("fault left early");
	AST_SHUT: assert property ((i_flags.ss_below_off && !o_fault)[*5] |-> !hs && !ls)
		else $error("drive on in shutdown");
	AST_DUTY: assert property (hs_len_r <= PERIOD_CYC * DUTY_PCT / 100)
		else $error("duty too long");
	AST_DIS_OFF: assert property (o_fault && dis && i_flags.ss_empty |-> ##[1:4] !dis)
		else $error("discharge kept on");
	AST_RECHG: assert property (o_fault && !dis && i_flags.ss_at_1v3 && o_oc_count != 3'h0
		|-> ##[1:4] dis)
		else $error("no redischarge");
endmodule
bind ohf_sequencer ohf_seq_sva #(.PERIOD_CYC(PERIOD_CYC), .DUTY_PCT(DUTY_PCT)) i_ohf_seq_sva (
	.i_clock, .i_nrst, .i_flags, .o_high_side_gate_drive, .o_low_side_gate_drive,
	.o_softstart_discharge, .o_fault, .o_oc_count);

/* sim/ohf_stage.sv */
// Purpose: power stage and soft-start capacitor model
// Assumes: cap level in steps, 30 is near 1.3 V, 40 is full
// Notes: phase node simply follows the high-side gate
`timescale 1ns/100ps
module ohf_stage (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_hs,
	input wire logic i_dis,
	output logic o_phase,
	output logic o_empty,
	output logic o_at_1v3
);
	logic [5:0] v_r, v_nxt;
	logic [1:0] pre_r, pre_nxt;
	// Fast discharge, charge one step per four clocks so soft-start spans periods
	always_comb begin
		pre_nxt = pre_r + 2'h1;
		v_nxt = v_r;
		if (i_dis)
			v_nxt = (v_r == 6'h00) ? v_r : v_r - 6'h01;
		else if (pre_r == 2'h3 && v_r != 6'h28)
			v_nxt = v_r + 6'h01;
	end
	// Cap level and charge prescaler
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			v_r <= 6'h00;
			pre_r <= 2'h0;
		end else begin
			v_r <= v_nxt;
			pre_r <= pre_nxt;
		end
	end
	assign o_phase = i_hs;
	assign o_empty = v_r == 6'h00;
	assign o_at_1v3 = v_r >= 6'h1e;
endmodule

/* sim/ohf_sequencer_tb.sv */
// Purpose: self-checking bench for the hiccup fault sequencer
// Assumes: short period of 50 clocks
// Notes: cap flags come from the stage model
`timescale 1ns/100ps
module ohf_sequencer_tb;
	import ohf_pkg::*;
	typedef struct {logic [7:0] f; int n; logic [6:0] e, m;} ohf_row_t;
	ohf_row_t rows [5] = '{'{8'h05, 60, 7'h00, 7'h40}, '{8'h07, 200, 7'h00, 7'h1f},
		'{8'h09, 10, 7'h00, 7'h70}, '{8'h01, 30, 7'h00, 7'h60}, '{8'h07, 200, 7'h00, 7'h1f}};
	logic clk = 0, nrst = 0, hs, ls, dis, flt, ph, emp, at, dp;
	logic [2:0] cnt;
	ohf_flags_t tf = '0, fl;
	int errors = 0, n_checks = 0, k, nd;
	wire logic [6:0] o = {hs, ls, dis, flt, cnt};
	always #2.5 clk = ~clk;
	// Cap and phase flags come from the stage model
	always_comb begin
		fl = tf;
		fl.phase_high = ph;
		fl.ss_empty = emp;
		fl.ss_at_1v3 = at;
	end
	ohf_sequencer #(.PERIOD_CYC(50)) i_ohf_sequencer (.i_clock(clk), .i_nrst(nrst), .i_flags(fl),
		.o_high_side_gate_drive(hs), .o_low_side_gate_drive(ls), .o_softstart_discharge(dis),
		.o_fault(flt), .o_oc_count(cnt));
	ohf_stage i_ohf_stage (.i_clock(clk), .i_nrst(nrst), .i_hs(hs), .i_dis(dis), .o_phase(ph),
		.o_empty(emp), .o_at_1v3(at));
	task chk(input logic [6:0] s, input logic [6:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#100000;
		errors++;
		give_verdict();
	end
	initial begin
		repeat (10) @(negedge clk);
		chk(o, 7'h00);
		nrst = 1;
		foreach (rows[i]) begin
			tf = rows[i].f;
			repeat (rows[i].n) @(negedge clk);
			chk(o & rows[i].m, rows[i].e);
		end
		// Sustained trip: seven counted pulses then hiccup
		tf = 8'h87;
		for (k = 0; flt !== 1'b1 && k < 3000; k++) @(negedge clk);
		chk(o, 7'h1e);
		nd = 1;
		dp = 1;
		for (k = 0; flt === 1'b1 && k < 5000; k++) begin
			@(negedge clk);
			if (dis && !dp && flt) nd++;
			dp = dis;
		end
		chk(7'(nd), 7'h07);
		// Two period ends pass in soft-start with trips still firing
		repeat (100) @(negedge clk);
		chk(o & 7'h0f, 7'h00);
		// Once soft-start completes, trips count again towards a fresh fault
		for (k = 0; flt !== 1'b1 && k < 3000; k++) @(negedge clk);
		chk(o, 7'h1e);
		give_verdict();
	end
endmodule
